// *** hdl/sarseq_pkg.sv ***
// Purpose: Shared constants and types for the SAR converter sequencer.
// Assumes: APB byte addresses; each register takes one aligned word.
// Notes: Printed offsets are not word multiples, so they are indices.
package sarseq_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] IDX_P0_LOW = 8'h60;
  localparam logic [7:0] IDX_P0_HIGH = 8'h61;
  localparam logic [7:0] IDX_P1_LOW = 8'h62;
  localparam logic [7:0] IDX_P1_HIGH = 8'h63;
  localparam logic [7:0] IDX_P2_LOW = 8'h64;
  localparam logic [7:0] IDX_P2_HIGH = 8'h65;
  localparam logic [7:0] IDX_P3_LOW = 8'h66;
  localparam logic [7:0] IDX_P3_HIGH = 8'h67;
  localparam logic [7:0] IDX_CONTROL = 8'h68;
  localparam logic [7:0] IDX_SETUP = 8'h69;
  localparam logic [7:0] IDX_PORT = 8'h6A;
  // Control register fields.
  localparam int CTL_END = 7;
  localparam int CTL_BUSY = 6;
  localparam int CTL_REPEAT = 5;
  localparam int CTL_SCAN = 4;
  localparam int CTL_START = 2;
  localparam logic [7:0] CTL_ONES = 8'h0B;
  // Setup register fields.
  localparam int SET_LADDER = 7;
  localparam int SET_DUR_LO = 4;
  localparam int SET_CH_LO = 0;
  localparam logic [7:0] SET_ONES = 8'h48;
  localparam logic [7:0] LOW_ONES = 8'h3F;
  // Result width and ladder steps.
  localparam int RES_BITS = 10;
  localparam int LADDER_STEPS = 1024;
  // Base conversion length in system states for duration code 00.
  localparam logic [11:0] BASE_STATES = 12'h0A0;
  // Ladder settle time, which software must respect.
  localparam int LADDER_SETTLE_US = 3;
  localparam int CLK_MHZ = 125;
  localparam int LADDER_SETTLE_CYC = LADDER_SETTLE_US * CLK_MHZ;
  // Sequencer states, Gray coded along the usual path.
  typedef enum logic [1:0]
  {
    SQ_IDLE = 2'b00,
    SQ_CONV = 2'b01,
    SQ_NEXT = 2'b11
  } sarseq_state_t;
  // Bus request bundle.
  typedef struct packed
  {
    logic sel;
    logic en;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sarseq_apb_t;
endpackage : sarseq_pkg

// *** hdl/sarseq_top.sv ***
// Purpose: Sequencer and register file of an eight-input 10-bit SAR ADC.
// Assumes: Comparator sits outside; it answers each trial within a cycle.
// Notes: Registers reached over APB; no wait states, no errors.
// Contract
// R1 - Ten-bit result, one bit per step, MSB first
// R2 - Trial codes index a 1024-step reference ladder
// R3 - Ladder switch opens when enable is 0
// R4 - Software waits 3 us after enabling ladder
// R5 - Fixed mode selects one input of eight
// R6 - Scan mode converts chosen sequence ascending
// R7 - Channel field resets to zero
// R8 - Unused inputs readable as digital port bits
// R9 - Start write begins conversion, busy set
// R10 - Repeat and scan bits give four modes
// R11 - Repeat modes restart without further starts
// R12 - Duration field resets to 160-state setting
// R13 - Single end sets end, clears busy, interrupts
// R14 - Software keeps interrupt disabled in repeat
// R15 - Repeat off finishes current conversion then stops; in scan mode the code first runs on to the last channel of the sequence
// R16 - Four result pairs shared by channel pairs
// R17 - Repeat mode overwrites pair each conversion
// R18 - Result registers read-only
// R19 - Low byte read clears end flag
// R20 - High byte bits 9..2, low bits 7..6
// R21 - Unused bits read as one
// R22 - Software stops converter before halt
// R23 - Scan codes map ascending sequences
// R24 - Duration codes give 160,320,640,1280 states
// R25 - Start while busy is ignored
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
module sarseq_top
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog side.
  input wire logic comp_above,
  input wire logic [7:0] pin_digital,
  output logic [2:0] mux_select,
  output logic [9:0] ladder_tap,
  output logic ladder_switch_enable,
  output logic comp_enable,
  output logic conv_end_irq
);
  // Bundled bus request.
  sarseq_pkg::sarseq_apb_t req;
  assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr,
                 wdata: pwdata};

  // Register index of the current access, or all ones if misaligned or above address bit 9.
  function automatic logic [7:0] reg_index(input logic [31:0] a);
    reg_index = (a[1:0] == 2'h0 && a[31:10] == '0) ? a[9:2] : 8'hFF;
  endfunction : reg_index

  // Control and setup state.
  logic end_flag;
  logic busy_flag;
  logic repeat_bit;
  logic scan_bit;
  logic [1:0] duration_field;
  logic [2:0] channel_field;
  // Sequencer state.
  sarseq_pkg::sarseq_state_t state;
  logic [2:0] cur_ch;
  logic [3:0] bit_idx;
  logic [9:0] trial;
  logic [11:0] step_cnt;
  logic [11:0] step_len;
  // Results, one per channel pair.
  logic [9:0] result [4];
  // Synchronised digital pins and comparator.
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic comp_s1;
  logic comp_s2;

  logic wr_acc;
  logic rd_acc;
  logic [7:0] idx;
  logic start_req;
  logic conv_done;
  logic [2:0] first_ch;
  logic [2:0] last_ch;
  assign idx = reg_index(req.addr);
  assign wr_acc = req.sel && req.en && req.wr;
  assign rd_acc = req.sel && req.en && !req.wr;
  assign start_req = wr_acc && idx == sarseq_pkg::IDX_CONTROL
                     && req.wdata[sarseq_pkg::CTL_START];
  // Each approximation step lasts a tenth of the conversion states.
  assign step_len = (sarseq_pkg::BASE_STATES << duration_field) / 12'h00A; // [R24]
  assign conv_done = state == sarseq_pkg::SQ_CONV && bit_idx == 4'h0
                     && step_cnt == step_len - 12'h001;
  // Scan runs climb from input 0 or 4 up to the coded channel.
  assign first_ch = scan_bit ? {channel_field[2], 2'b00} : channel_field; // [R23]
  assign last_ch = channel_field; // [R6]

  // Two-flop synchronisers for the pins and the comparator.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
    end
    else
    begin
      pin_s1 <= pin_digital;
      pin_s2 <= pin_s1;
      comp_s1 <= comp_above;
      comp_s2 <= comp_s1;
    end
  end

  // Mode and setup register writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      repeat_bit <= 1'b0;
      scan_bit <= 1'b0;
      duration_field <= 2'h0; // [R12]
      channel_field <= 3'h0; // [R7]
      ladder_switch_enable <= 1'b0;
    end
    else if (wr_acc && idx == sarseq_pkg::IDX_CONTROL)
    begin
      // Modes come from two bits.
      repeat_bit <= req.wdata[sarseq_pkg::CTL_REPEAT]; // [R10]
      scan_bit <= req.wdata[sarseq_pkg::CTL_SCAN];
    end
    else if (wr_acc && idx == sarseq_pkg::IDX_SETUP)
    begin
      // Writing 0 opens the ladder switch.
      ladder_switch_enable <= req.wdata[sarseq_pkg::SET_LADDER]; // [R3]
      duration_field <= req.wdata[sarseq_pkg::SET_DUR_LO +: 2];
      channel_field <= req.wdata[sarseq_pkg::SET_CH_LO +: 3];
    end
  end

  // Conversion sequencer: steps, channel walk and repeat handling.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= sarseq_pkg::SQ_IDLE;
      cur_ch <= 3'h0;
      bit_idx <= 4'h9;
      trial <= 10'h000;
      step_cnt <= 12'h000;
      busy_flag <= 1'b0;
    end
    else
    begin
      case (state)
        sarseq_pkg::SQ_IDLE:
        begin
          // Start begins a conversion; busy starts are not seen here.
          if (start_req) // [R9] [R25]
          begin
            state <= sarseq_pkg::SQ_CONV;
            busy_flag <= 1'b1;
            cur_ch <= first_ch; // [R5]
            bit_idx <= 4'h9;
            trial <= 10'h200;
            step_cnt <= 12'h000;
          end
        end
        sarseq_pkg::SQ_CONV:
        begin
          if (step_cnt != step_len - 12'h001)
            step_cnt <= step_cnt + 12'h001;
          else
          begin
            // Keep or drop the trial bit, then try the next lower bit.
            step_cnt <= 12'h000;
            trial[bit_idx] <= comp_s2; // [R1] [R2]
            if (bit_idx == 4'h0)
              state <= sarseq_pkg::SQ_NEXT;
            else
            begin
              trial[bit_idx - 4'h1] <= 1'b1;
              bit_idx <= bit_idx - 4'h1;
            end
          end
        end
        sarseq_pkg::SQ_NEXT:
        begin
          bit_idx <= 4'h9;
          trial <= 10'h200;
          if (cur_ch != last_ch)
          begin
            cur_ch <= cur_ch + 3'h1; // [R6]
            state <= sarseq_pkg::SQ_CONV;
          end
          else if (repeat_bit)
          begin
            // Repeat restarts the sequence by itself.
            cur_ch <= first_ch; // [R11]
            state <= sarseq_pkg::SQ_CONV;
          end
          else
          begin
            // Repeat cleared: the finished conversion was the last.
            busy_flag <= 1'b0; // [R13] [R15]
            state <= sarseq_pkg::SQ_IDLE;
          end
        end
        default:
        begin
          state <= sarseq_pkg::SQ_IDLE;
          busy_flag <= 1'b0;
        end
      endcase
    end
  end

  // Result storage; the bus never writes it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
        result[i] <= 10'h000;
    end
    else if (conv_done)
    begin
      // Pair shared by ch and ch+4, no channel tag kept.
      result[cur_ch[1:0]] <= {trial[9:1], comp_s2}; // [R16] [R17] [R18]
    end
  end

  // End flag and interrupt pulse.
  logic seq_end;
  logic low_read;
  assign seq_end = state == sarseq_pkg::SQ_NEXT && cur_ch == last_ch
                   && !repeat_bit;
  assign low_read = rd_acc && idx >= sarseq_pkg::IDX_P0_LOW
                    && idx <= sarseq_pkg::IDX_P3_HIGH && !idx[0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      end_flag <= 1'b0;
      conv_end_irq <= 1'b0;
    end
    else
    begin
      conv_end_irq <= seq_end; // [R13]
      // Setting wins over a low-byte read in the same cycle.
      if (seq_end)
        end_flag <= 1'b1; // [R13]
      else if (low_read)
        end_flag <= 1'b0; // [R19]
    end
  end

  // Analog-facing outputs from flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mux_select <= 3'h0;
      ladder_tap <= 10'h000;
      comp_enable <= 1'b0;
    end
    else
    begin
      mux_select <= (state == sarseq_pkg::SQ_IDLE) ? channel_field : cur_ch;
      ladder_tap <= trial; // [R2]
      comp_enable <= state != sarseq_pkg::SQ_IDLE;
    end
  end

  // Read data mux; data registered in the setup cycle.
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (idx >= sarseq_pkg::IDX_P0_LOW && idx <= sarseq_pkg::IDX_P3_HIGH)
    begin
      // High byte holds bits 9..2, low byte bits 1..0 over ones.
      if (idx[0])
        rd_byte = result[idx[2:1]][9:2]; // [R20]
      else
        rd_byte = {result[idx[2:1]][1:0], 6'h00}
                  | sarseq_pkg::LOW_ONES; // [R21]
    end
    else if (idx == sarseq_pkg::IDX_CONTROL)
    begin
      rd_byte = {end_flag, busy_flag, repeat_bit, scan_bit, 4'h0}
                | sarseq_pkg::CTL_ONES; // [R21]
    end
    else if (idx == sarseq_pkg::IDX_SETUP)
    begin
      rd_byte = {ladder_switch_enable, 1'b0, duration_field, 1'b0,
                 channel_field} | sarseq_pkg::SET_ONES;
    end
    else if (idx == sarseq_pkg::IDX_PORT)
      rd_byte = pin_s2; // [R8]
  end

  // APB answer: one access cycle, no errors.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= req.sel && !req.en;
      pslverr <= 1'b0;
      if (req.sel && !req.en && !req.wr)
        prdata <= {24'h000000, rd_byte};
    end
  end

  // Assertions.
  property p_busy_on_start;
    @(posedge pclk) disable iff (!presetn)
    (state == sarseq_pkg::SQ_IDLE && start_req) |=> busy_flag;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) // [R9]
    else $error("Busy not set after start.");
  property p_end_clears_busy;
    @(posedge pclk) disable iff (!presetn)
    seq_end |=> (end_flag && !busy_flag && conv_end_irq);
  endproperty
  a_end_clears_busy: assert property (p_end_clears_busy) // [R13]
    else $error("End of sequence flags wrong.");
  property p_low_read_clears;
    @(posedge pclk) disable iff (!presetn)
    (low_read && !seq_end) |=> !end_flag;
  endproperty
  a_low_read_clears: assert property (p_low_read_clears) // [R19]
    else $error("Low read did not clear end flag.");
  property p_high_read_keeps;
    @(posedge pclk) disable iff (!presetn)
    (rd_acc && idx[0] && idx <= sarseq_pkg::IDX_P3_HIGH
     && idx >= sarseq_pkg::IDX_P0_LOW && end_flag) |=> end_flag;
  endproperty
  a_high_read_keeps: assert property (p_high_read_keeps) // [R19]
    else $error("High read changed end flag.");
  property p_busy_ignored;
    @(posedge pclk) disable iff (!presetn)
    (state == sarseq_pkg::SQ_CONV && start_req) |=>
      $stable(cur_ch) && state != sarseq_pkg::SQ_IDLE;
  endproperty
  a_busy_ignored: assert property (p_busy_ignored) // [R25]
    else $error("Start while busy disturbed conversion.");
  property p_repeat_restarts;
    @(posedge pclk) disable iff (!presetn)
    (state == sarseq_pkg::SQ_NEXT && cur_ch == last_ch && repeat_bit)
      |=> (state == sarseq_pkg::SQ_CONV && cur_ch == $past(first_ch));
  endproperty
  a_repeat_restarts: assert property (p_repeat_restarts) // [R11]
    else $error("Repeat did not restart sequence.");
  property p_result_stored;
    @(posedge pclk) disable iff (!presetn)
    conv_done |=> result[$past(cur_ch[1:0])] == {$past(trial[9:1]),
                                                 $past(comp_s2)};
  endproperty
  a_result_stored: assert property (p_result_stored) // [R17]
    else $error("Result not stored.");
  property p_low_ones;
    @(posedge pclk) disable iff (!presetn)
    (req.sel && !req.en && !req.wr && !idx[0]
     && idx >= sarseq_pkg::IDX_P0_LOW && idx <= sarseq_pkg::IDX_P3_HIGH)
      |=> prdata[7:0] == {$past(result[idx[2:1]][1:0]), 6'h3F};
  endproperty
  a_low_ones: assert property (p_low_ones) // [R21] [R20]
    else $error("Low byte layout wrong.");
  property p_scan_range;
    @(posedge pclk) disable iff (!presetn)
    state == sarseq_pkg::SQ_CONV |-> cur_ch <= last_ch;
  endproperty
  a_scan_range: assert property (p_scan_range) // [R6]
    else $error("Channel outside sequence.");
  c_single: cover property (@(posedge pclk) disable iff (!presetn)
    seq_end && !scan_bit);
  c_scan: cover property (@(posedge pclk) disable iff (!presetn)
    seq_end && scan_bit);
  c_repeat: cover property (@(posedge pclk) disable iff (!presetn)
    state == sarseq_pkg::SQ_NEXT && repeat_bit);
endmodule : sarseq_top

// *** test/sar_adc_sequencer_test.sv ***
// Purpose: Self-checking bench for the SAR converter sequencer.
// Assumes: Zero-wait APB slave; comparator model on the analog side.
// Notes: Repeat runs are stopped by software before the end.
`timescale 1ns/100ps
module sar_adc_sequencer_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic comp_above, ladder_switch_enable, comp_enable, conv_end_irq;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] pin_digital;
  logic [2:0] mux_select;
  logic [9:0] ladder_tap;
  logic [7:0][9:0] level;
  int err_total, n_tests, waited;

  sarseq_top u_sarseq_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_above(comp_above), .pin_digital(pin_digital),
    .mux_select(mux_select), .ladder_tap(ladder_tap),
    .ladder_switch_enable(ladder_switch_enable),
    .comp_enable(comp_enable), .conv_end_irq(conv_end_irq));
  sarseq_analog u_sarseq_analog (.pclk(pclk), .level(level),
    .mux_select(mux_select), .ladder_tap(ladder_tap),
    .ladder_switch_enable(ladder_switch_enable),
    .comp_enable(comp_enable), .comp_above(comp_above));

  // Counts each compare and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("compares %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // A wait that ran out counts as a mismatch and ends the run.
  task automatic hang;
    err_total++;
    $display("unexpected at %0t: wait ran out", $time);
    test_done();
  endtask : hang

  // One APB transfer; an edge passes first so strobes never clash.
  task automatic apb(input logic wr, input logic [7:0] idx,
    input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
      hang();
  endtask : apb

  // Control and setup register shorthands.
  task automatic cr(input logic wr, input logic [7:0] v);
    apb(wr, sarseq_pkg::IDX_CONTROL, v);
  endtask : cr
  task automatic sr(input logic wr, input logic [7:0] v);
    apb(wr, sarseq_pkg::IDX_SETUP, v);
  endtask : sr

  // Waits for the end pulse, counting cycles into waited.
  task automatic wait_irq(input int n);
    for (waited = 1; waited <= n; waited++)
    begin
      @(posedge pclk);
      if (conv_end_irq === 1'b1)
        break;
    end
    if (waited > n)
      hang();
  endtask : wait_irq

  // Reset values, read-as-one bits and an unmapped place.
  task automatic t_reset;
    sr(1'b0, 8'h00);
    chk(rd, 32'h48);
    cr(1'b0, 8'h00);
    chk(rd, 32'h0B);
    apb(1'b0, 8'h70, 8'h00);
    chk(rd, 32'h0); 
    $display("reset test done");
  endtask : t_reset

  // Fixed single on input 3, a start while busy, flags and reads.
  task automatic t_fixed;
    sr(1'b1, 8'h83);
    repeat (sarseq_pkg::LADDER_SETTLE_CYC) @(posedge pclk);
    cr(1'b1, 8'h04);
    cr(1'b0, 8'h00);
    chk(rd[6], 1'b1);
    chk(mux_select, 3'h3);
    cr(1'b1, 8'h04); // Ignored while busy.
    wait_irq(3000);
    cr(1'b0, 8'h00);
    chk(rd[7:4], 4'h8);
    apb(1'b1, sarseq_pkg::IDX_P3_HIGH, 8'hFF);
    apb(1'b0, sarseq_pkg::IDX_P3_HIGH, 8'h00);
    chk(rd, 32'h55);
    cr(1'b0, 8'h00);
    chk(rd[7], 1'b1);
    apb(1'b0, sarseq_pkg::IDX_P3_LOW, 8'h00);
    chk(rd, 32'h7F);
    cr(1'b0, 8'h00);
    chk(rd[7], 1'b0);
    $display("fixed test done");
  endtask : t_fixed

  // Every duration code on input 2, timed from start to end pulse.
  task automatic t_speed;
    int d;
    for (d = 0; d < 4; d++)
    begin
      sr(1'b1, 8'h82 | 8'(d << 4));
      cr(1'b1, 8'h04);
      wait_irq(3000);
      chk(waited >= 160 << d && waited < (160 << d) + 24, 1'b1);
      apb(1'b0, sarseq_pkg::IDX_P2_HIGH, 8'h00);
      chk(rd, 32'hFF);
    end
    $display("speed test done");
  endtask : t_speed

  // Every scan code; length and last result show the sequence.
  task automatic t_scan;
    int c, n, last;
    for (c = 0; c < 8; c++)
    begin
      n = c < 4 ? c + 1 : (c == 7 ? 4 : c - 3);
      last = c;
      sr(1'b1, 8'h80 | 8'(c));
      cr(1'b1, 8'h14);
      wait_irq(3000);
      chk(waited >= 160 * n && waited < 170 * n + 10, 1'b1);
      apb(1'b0, sarseq_pkg::IDX_P0_HIGH + 8'(2 * (last % 4)), 8'h00);
      chk(rd, {24'h0, level[last][9:2]});
    end
    $display("scan test done");
  endtask : t_scan

  // Fixed then scan repeat; results follow the input, then stop.
  task automatic t_repeat;
    int m;
    for (m = 0; m < 2; m++)
    begin
      sr(1'b1, 8'h81);
      cr(1'b1, 8'h24 | 8'(m << 4));
      repeat (800) @(posedge pclk);
      level[1] <= 10'h2E7 - 10'(m);
      repeat (800) @(posedge pclk);
      apb(1'b0, sarseq_pkg::IDX_P1_LOW, 8'h00);
      chk(rd, {24'h0, 2'(3 - m), 6'h3F});
      cr(1'b1, 8'h00);
      cr(1'b0, 8'h00);
      chk(rd[6], 1'b1);
      repeat (400) @(posedge pclk);
      cr(1'b0, 8'h00);
      chk(rd[6], 1'b0);
    end
    $display("repeat test done");
  endtask : t_repeat

  // Digital port read, then the ladder opened and speed parked.
  task automatic t_port;
    apb(1'b0, sarseq_pkg::IDX_PORT, 8'h00);
    chk(rd, 32'hA5);
    sr(1'b1, 8'h00);
    @(posedge pclk);
    chk(ladder_switch_enable, 1'b0);
    sr(1'b0, 8'h00);
    chk(rd, 32'h48);
    $display("port test done");
  endtask : t_port

  // Free-running 125 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pin_digital = 8'hA5;
    level = {10'h3A5, 10'h05A, 10'h2C3, 10'h1F0,
      10'h155, 10'h3FF, 10'h001, 10'h200};
    err_total = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fixed();
    t_speed();
    t_scan();
    t_repeat();
    t_port();
    test_done();
  end
endmodule : sar_adc_sequencer_test

// *** test/sarseq_analog.sv ***
// Purpose: Comparator and pin model for the SAR sequencer bench.
// Assumes: Each input level is a 10-bit code set by the bench.
// Notes: Output wanders while idle, so stale answers are never trusted.
`timescale 1ns/100ps
module sarseq_analog
(
  // Clock.
  input wire logic pclk,
  // Levels set by the bench.
  input wire logic [7:0][9:0] level,
  // Design side.
  input wire logic [2:0] mux_select,
  input wire logic [9:0] ladder_tap,
  input wire logic ladder_switch_enable,
  input wire logic comp_enable,
  output logic comp_above
);
  // Toggles every cycle; stands in for an unpowered comparator.
  logic wander = 1'b0;

  // Free-running toggle.
  always @(posedge pclk)
  begin
    wander <= ~wander;
  end

  // At or above the tap of the 1024-step ladder reads as above.
  assign comp_above = (comp_enable && ladder_switch_enable) ?
    (level[mux_select] >= ladder_tap) : wander;
endmodule : sarseq_analog
